// *** core/cih_regs.svh ***
`ifndef CIH_REGS_SVH
`define CIH_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CIH_OFS_PRI_EN 6'h00
`define CIH_OFS_EXT_EN1 6'h04
`define CIH_OFS_EXT_EN2 6'h08
`define CIH_OFS_PRIO 6'h0C
`define CIH_OFS_TCTL 6'h10
`define CIH_OFS_PEND 6'h14
`define CIH_OFS_ACTV 6'h18
`define CIH_OFS_STAT 6'h1C
`define CIH_OFS_MASK 6'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CIH_GLB_BIT 7
`define CIH_TRIG0_BIT 0
`define CIH_PEND0_BIT 1
`define CIH_TRIG1_BIT 2
`define CIH_PEND1_BIT 3
`define CIH_ST_CALL 0
`define CIH_ST_RETURN_FROM_INTERRUPT 1

// ----------------------------------------
// Sizes, vectors and reset values
// ----------------------------------------
`define CIH_NSRC 22
`define CIH_VEC_BASE 16'h0003
`define CIH_VEC_SHIFT 3
`define CIH_AUTOCLR 22'h0_0000
`define CIH_RST_BYTE 8'h00
`define CIH_RST_WORD 22'h0_0000

`endif

// *** core/cih_pkg.sv ***
package cih_pkg;

  // ----------------------------------------
  // Sequencer hand-off state
  // ----------------------------------------
  typedef enum logic [1:0] {
    CIH_RUN  = 2'b00,
    CIH_SKIP = 2'b01
  } cih_state_t;

  // Source index
  typedef logic [4:0] cih_src_t;

endpackage

// *** core/cih_ext_irq.sv ***
`timescale 1ns/1ps
`include "cih_regs.svh"

module cih_ext_irq (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Pin, active low
  input wire logic pin_n_i,
  // Control
  input wire logic trig_edge_i,
  input wire logic ack_i,
  input wire logic sw_wr_i,
  input wire logic sw_val_i,
  // Flag
  output logic pending_o
);

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic sync1_reg; // First stage, read by sync2 only
  logic sync2_reg; // Safe pin level
  logic prev_reg; // Delayed level for edge detect
  logic pend_next;
  wire fall_w = prev_reg & ~sync2_reg; // Falling edge seen

  // Idle pin is high, so reset to high
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_n_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ----------------------------------------
  // Flag: latched edge or live level
  // ----------------------------------------
  // Edge: new edge beats ack and software clear
  // Level: no latch, a held pin keeps asking
  assign pend_next = trig_edge_i ?
    (((sw_wr_i ? sw_val_i : pending_o) & ~ack_i) | fall_w) :
    ~sync2_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pending_o <= 1'b0;
    end else begin
      pending_o <= pend_next;
    end
  end

  AST_EXT_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !trig_edge_i |=> pending_o == !$past(sync2_reg))
    else $error("Level flag does not follow pin");
  AST_EXT_EDGE_CLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (trig_edge_i && ack_i && !fall_w && !sw_wr_i) |=> !pending_o)
    else $error("Edge flag not cleared on vector");
  AST_EXT_FALL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (trig_edge_i && fall_w) |=> pending_o)
    else $error("Falling edge lost");

endmodule

// *** core/cih_top.sv ***
`timescale 1ns/1ps
`include "cih_regs.svh"

// Function
// - 22 sources, two levels, flags in registers
// - Event sets its flag regardless of enables
// - Enabled flag calls vector after instruction ends
// - Return resumes the interrupted instruction stream
// - Disabled source's flag raises no request
// - Source enables count only with global enable
// - Global enable low blocks every source
// - Some flags cleared on vector, others software
// - Still pending after return: one instruction first
// - Software setting a flag acts as event, except external flags in level mode
// - External inputs active low, edge or level
// - External flags at control bits 1, 3
// - Edge mode flag cleared on vector
// - Level mode flag follows the pin

module cih_top #(
  parameter logic [21:0] AUTOCLR_MASK = `CIH_AUTOCLR
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Interrupt sources
  input wire logic ext_irq0_n_i,
  input wire logic ext_irq1_n_i,
  input wire logic [21:2] src_event_i,
  // CPU sequencer
  input wire logic instr_done_i,
  input wire logic return_from_interrupt_i,
  output logic call_req_o,
  output logic [4:0] call_src_o,
  output logic [15:0] call_addr_o,
  output logic irq_req_o,
  // Block interrupt
  output logic irq_o
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // External flags clear themselves; mask bits there make no sense
  if (AUTOCLR_MASK[1:0] != 2'b00) begin : g_chk_mask
    $error("AUTOCLR_MASK bits 1:0 must be zero");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Address match
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction

  // Lowest set bit wins within a level
  function automatic cih_pkg::cih_src_t first_set(input logic [21:0] v);
    first_set = 5'h00;
    for (int i = `CIH_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic wait_reg; // Waitrequest, high at rest
  logic [31:0] rdata_reg; // Read data holding
  logic [7:0] pri_en_reg; // Global enable and sources 0..5
  logic [7:0] ext_en1_reg; // Sources 6..13
  logic [7:0] ext_en2_reg; // Sources 14..21
  logic [21:0] prio_reg; // One means high level
  logic [1:0] trig_reg; // Edge select per external input
  logic [21:2] pend_reg; // Peripheral pending flags
  logic [1:0] stat_reg; // Sticky block events
  logic [1:0] mask_reg; // Block interrupt mask
  logic in_lo_reg; // Low routine running
  logic in_hi_reg; // High routine running
  cih_pkg::cih_state_t state_reg; // Post-return hold
  logic call_req_reg;
  cih_pkg::cih_src_t call_src_reg;
  logic [15:0] call_addr_reg;
  logic irq_req_reg;
  logic irq_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req_w = avs_read_i | avs_write_i;
  wire wr_go = avs_write_i & ~wait_reg; // Write commits here
  wire rd_go = avs_read_i & ~wait_reg; // Read completes here
  wire wr_pri = wr_go & hit(avs_address_i, `CIH_OFS_PRI_EN);
  wire wr_en1 = wr_go & hit(avs_address_i, `CIH_OFS_EXT_EN1);
  wire wr_en2 = wr_go & hit(avs_address_i, `CIH_OFS_EXT_EN2);
  wire wr_prio = wr_go & hit(avs_address_i, `CIH_OFS_PRIO);
  wire wr_tctl = wr_go & hit(avs_address_i, `CIH_OFS_TCTL);
  wire wr_pend = wr_go & hit(avs_address_i, `CIH_OFS_PEND);
  wire wr_mask = wr_go & hit(avs_address_i, `CIH_OFS_MASK);
  wire rd_stat = rd_go & hit(avs_address_i, `CIH_OFS_STAT);
  wire [31:0] wd_pri = merge({24'h00_0000, pri_en_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wd_en1 = merge({24'h00_0000, ext_en1_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wd_en2 = merge({24'h00_0000, ext_en2_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wd_prio = merge({10'h000, prio_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wd_pend = merge({10'h000, pend_reg, 2'b00}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wd_mask = merge({30'h0000_0000, mask_reg}, avs_writedata_i, avs_byteenable_i);
  wire tctl_lane = wr_tctl & avs_byteenable_i[0];

  // ----------------------------------------
  // External inputs
  // ----------------------------------------
  wire [1:0] ext_pin_n = {ext_irq1_n_i, ext_irq0_n_i};
  wire [1:0] ext_pend; // Flags at control bits 1 and 3
  wire [1:0] sw_ext_val = {avs_writedata_i[`CIH_PEND1_BIT], avs_writedata_i[`CIH_PEND0_BIT]};
  logic [21:0] ack_vec; // One-hot vectored source

  for (genvar k = 0; k < 2; k++) begin : g_ext
    cih_ext_irq u_ext (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .pin_n_i(ext_pin_n[k]),
      .trig_edge_i(trig_reg[k]),
      .ack_i(ack_vec[k]),
      .sw_wr_i(tctl_lane),
      .sw_val_i(sw_ext_val[k]),
      .pending_o(ext_pend[k])
    );
  end

  // ----------------------------------------
  // Request qualification and arbitration
  // ----------------------------------------
  wire glb_en = pri_en_reg[`CIH_GLB_BIT];
  wire [21:0] en_all = {ext_en2_reg, ext_en1_reg, pri_en_reg[5:0]};
  wire [21:0] pend_all = {pend_reg, ext_pend};
  // Global gate over every per-source enable
  wire [21:0] eff_req = pend_all & en_all & {`CIH_NSRC{glb_en}};
  wire [21:0] hi_cand = eff_req & prio_reg;
  wire [21:0] lo_cand = eff_req & ~prio_reg;
  // High may interrupt low; nothing interrupts high
  wire can_hi = (|hi_cand) & ~in_hi_reg;
  wire can_lo = (|lo_cand) & ~in_hi_reg & ~in_lo_reg;
  wire any_req = can_hi | can_lo;
  wire [4:0] win_src = can_hi ? first_set(hi_cand) : first_set(lo_cand);
  wire in_run = (state_reg == cih_pkg::CIH_RUN);
  // Call only at an instruction boundary, never on the return itself
  wire take = instr_done_i & ~return_from_interrupt_i & any_req & in_run;
  wire take_hi = take & can_hi;
  wire [15:0] vec_addr = `CIH_VEC_BASE + (16'(win_src) << `CIH_VEC_SHIFT);

  assign ack_vec = take ? (22'h0_0001 << win_src) : 22'h0_0000;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  logic [21:2] pend_next;
  logic [1:0] stat_next;
  logic [1:0] mask_next;
  cih_pkg::cih_state_t state_next;

  // Events last so they win over software and vector clears
  assign pend_next = ((wr_pend ? wd_pend[21:2] : pend_reg)
                      & ~(ack_vec[21:2] & AUTOCLR_MASK[21:2]))
                     | src_event_i;
  // Read clears; a same-cycle event still lands
  assign stat_next = (rd_stat ? 2'b00 : stat_reg) | {return_from_interrupt_i, take};
  assign mask_next = wr_mask ? wd_mask[1:0] : mask_reg;

  // Hold state: after a return one instruction must run
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cih_pkg::CIH_RUN: begin
        if (return_from_interrupt_i) begin
          state_next = cih_pkg::CIH_SKIP;
        end
      end
      cih_pkg::CIH_SKIP: begin
        if (instr_done_i && !return_from_interrupt_i) begin
          state_next = cih_pkg::CIH_RUN;
        end
      end
      default: begin
        state_next = cih_pkg::CIH_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [31:0] rd_tctl = {28'h000_0000, ext_pend[1], trig_reg[1], ext_pend[0], trig_reg[0]};
  wire [31:0] rd_actv = {22'h00_0000, state_reg, 1'b0, call_src_reg, in_hi_reg, in_lo_reg};
  wire [5:0] ra = avs_address_i;
  wire [31:0] rd_mux =
    hit(ra, `CIH_OFS_PRI_EN) ? {24'h00_0000, pri_en_reg} :
    hit(ra, `CIH_OFS_EXT_EN1) ? {24'h00_0000, ext_en1_reg} :
    hit(ra, `CIH_OFS_EXT_EN2) ? {24'h00_0000, ext_en2_reg} :
    hit(ra, `CIH_OFS_PRIO) ? {10'h000, prio_reg} :
    hit(ra, `CIH_OFS_TCTL) ? rd_tctl :
    hit(ra, `CIH_OFS_PEND) ? {10'h000, pend_reg, 2'b00} :
    hit(ra, `CIH_OFS_ACTV) ? rd_actv :
    hit(ra, `CIH_OFS_STAT) ? {30'h0000_0000, stat_reg} :
    hit(ra, `CIH_OFS_MASK) ? {30'h0000_0000, mask_reg} :
    32'h0000_0000; // Unmapped reads zero

  // ----------------------------------------
  // Bus slave flops
  // ----------------------------------------
  // Fixed one wait cycle: capture on first edge, finish on second
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(req_w & wait_reg);
      if (avs_read_i && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Enables, priorities and trigger selects
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pri_en_reg <= `CIH_RST_BYTE;
      ext_en1_reg <= `CIH_RST_BYTE;
      ext_en2_reg <= `CIH_RST_BYTE;
      prio_reg <= `CIH_RST_WORD;
      trig_reg <= 2'b00;
      mask_reg <= 2'b00;
    end else begin
      if (wr_pri) begin
        pri_en_reg <= wd_pri[7:0];
      end
      if (wr_en1) begin
        ext_en1_reg <= wd_en1[7:0];
      end
      if (wr_en2) begin
        ext_en2_reg <= wd_en2[7:0];
      end
      if (wr_prio) begin
        prio_reg <= wd_prio[21:0];
      end
      if (tctl_lane) begin
        trig_reg <= {avs_writedata_i[`CIH_TRIG1_BIT], avs_writedata_i[`CIH_TRIG0_BIT]};
      end
      mask_reg <= mask_next;
    end
  end

  // Flags and sticky status
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pend_reg <= 20'h0_0000;
      stat_reg <= 2'b00;
      irq_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & mask_next);
    end
  end

  // ----------------------------------------
  // Sequencer side
  // ----------------------------------------
  // Return closes the innermost routine, high before low
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      in_lo_reg <= 1'b0;
      in_hi_reg <= 1'b0;
      state_reg <= cih_pkg::CIH_RUN;
    end else begin
      state_reg <= state_next;
      if (return_from_interrupt_i) begin
        if (in_hi_reg) begin
          in_hi_reg <= 1'b0;
        end else begin
          in_lo_reg <= 1'b0;
        end
      end else if (take_hi) begin
        in_hi_reg <= 1'b1;
      end else if (take) begin
        in_lo_reg <= 1'b1;
      end
    end
  end

  // Call pulse with source and vector
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      call_req_reg <= 1'b0;
      call_src_reg <= 5'h00;
      call_addr_reg <= 16'h0000;
      irq_req_reg <= 1'b0;
    end else begin
      call_req_reg <= take;
      irq_req_reg <= any_req;
      if (take) begin
        call_src_reg <= win_src;
        call_addr_reg <= vec_addr;
      end
    end
  end

  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o = rdata_reg;
  assign call_req_o = call_req_reg;
  assign call_src_o = call_src_reg;
  assign call_addr_o = call_addr_reg;
  assign irq_req_o = irq_req_reg;
  assign irq_o = irq_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_return_from_interrupt_then_hold;
    return_from_interrupt_i ##1 ((state_reg == cih_pkg::CIH_SKIP) && !call_req_o);
  endsequence

  sequence s_hold_boundary;
    (state_reg == cih_pkg::CIH_SKIP) && instr_done_i && !return_from_interrupt_i;
  endsequence

  AST_PEND_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (|src_event_i) |=> ((pend_reg & $past(src_event_i)) == $past(src_event_i)))
    else $error("Event did not set its flag");
  AST_GLB_BLOCK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !glb_en |=> !call_req_o)
    else $error("Call with global enable low");
  AST_CALL_BOUNDARY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    call_req_o |-> $past(instr_done_i) && call_addr_o == `CIH_VEC_BASE + (16'(call_src_o) << `CIH_VEC_SHIFT))
    else $error("Call off boundary or wrong vector");
  AST_CALL_ENABLED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    call_req_o |-> $past(eff_req[win_src]))
    else $error("Call for a disabled source");
  AST_RETURN_FROM_INTERRUPT_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    return_from_interrupt_i |-> s_return_from_interrupt_then_hold)
    else $error("Hold state missed after return");
  AST_HOLD_SKIP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_hold_boundary |=> !call_req_o ##1 (state_reg == cih_pkg::CIH_RUN || $past(return_from_interrupt_i)))
    else $error("Re-entry before one instruction");
  AST_NO_PREEMPT_HI: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    call_req_o |-> !$past(in_hi_reg) && ($past(in_lo_reg) -> $past(prio_reg[win_src])))
    else $error("Illegal nesting");
  AST_SW_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_pend && !take) |=> ((pend_reg & $past(wd_pend[21:2])) == $past(wd_pend[21:2])))
    else $error("Software set of a flag lost");
  AST_AUTOCLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (take && !wr_pend && !AUTOCLR_MASK[win_src] && win_src > 5'd1) |=> pend_reg[$past(win_src)])
    else $error("Software-cleared flag dropped by hardware");

endmodule

// *** tb/cih_peer.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// External requesters on both pins
// ----------------------------------------
module cih_peer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Bench commands, one-cycle pulses
  input wire logic [1:0] lvl_req_i,
  input wire logic [1:0] edge_req_i,
  // Calls made by the handler
  input wire logic call_req_i,
  input wire logic [4:0] call_src_i,
  // Pins, active low, pulled up when idle
  output logic [1:0] pin_n_o
);
  logic [1:0] hold_reg; // Level request standing
  logic [2:0] pulse_reg [2]; // Edge pulse cycles left

  // Level holds until its own call; edge is a short low pulse
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_n_i) begin
        hold_reg[i] <= 1'b0;
        pulse_reg[i] <= 3'h0;
      end else begin
        // Pulse must outlast the pin synchroniser
        if (edge_req_i[i]) begin
          pulse_reg[i] <= 3'h4;
        end else if (pulse_reg[i] != 3'h0) begin
          pulse_reg[i] <= pulse_reg[i] - 3'h1;
        end
        if (lvl_req_i[i]) begin
          hold_reg[i] <= 1'b1;
        end else if (call_req_i && call_src_i == 5'(i)) begin
          hold_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Low while any request stands
  assign pin_n_o = ~(hold_reg | {pulse_reg[1] != 3'h0, pulse_reg[0] != 3'h0});
endmodule

// *** tb/cih_top_tb.sv ***
`timescale 1ns/1ps
`include "cih_regs.svh"

module cih_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0; // 20 MHz
  logic rst_n = 1'b0; // Synchronous reset
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq;
  logic [21:2] ev = 20'h0_0000; // Peripheral events
  logic done = 1'b0;
  logic return_from_interrupt = 1'b0;
  logic call_req;
  logic [4:0] call_src;
  logic [15:0] call_addr;
  logic irq_req;
  logic irq;
  logic [1:0] lvl = 2'b00;
  logic [1:0] edg = 2'b00;
  logic [1:0] pin_n;
  logic [31:0] q; // Scratch read data
  int fail_count = 0;
  int total_checks = 0;

  always #25 clk = ~clk;

  // Source 6 clears itself on vector, the other peripheral sources wait for software
  cih_top #(.AUTOCLR_MASK(22'h00_0040)) dut (
    .sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .ext_irq0_n_i(pin_n[0]),
    .ext_irq1_n_i(pin_n[1]), .src_event_i(ev), .instr_done_i(done), .return_from_interrupt_i(return_from_interrupt),
    .call_req_o(call_req), .call_src_o(call_src), .call_addr_o(call_addr),
    .irq_req_o(irq_req), .irq_o(irq));

  cih_peer peer (
    .sys_clk_i(clk), .rst_n_i(rst_n), .lvl_req_i(lvl), .edge_req_i(edg),
    .call_req_i(call_req), .call_src_i(call_src), .pin_n_o(pin_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon cycle; an idle edge first keeps drivers single per step
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    repeat (20) begin
      @(posedge clk);
      if (wreq === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
    if (!ok) begin
      fail_count++;
      print_verdict();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask

  // Instruction end (or return) pulse, then the call answer cycle
  task automatic step(input logic r, input logic exp);
    @(posedge clk);
    if (r) begin
      return_from_interrupt <= 1'b1;
    end else begin
      done <= 1'b1;
    end
    @(posedge clk);
    done <= 1'b0;
    return_from_interrupt <= 1'b0;
    @(posedge clk);
    check({31'h0, call_req}, {31'h0, exp});
  endtask

  task automatic call_chk(input int s);
    check({27'h0, call_src}, 32'(s));
    check({16'h0, call_addr}, 32'(`CIH_VEC_BASE + (s << `CIH_VEC_SHIFT)));
  endtask

  task automatic pulse_ev(input int s);
    @(posedge clk);
    ev[s] <= 1'b1;
    @(posedge clk);
    ev <= 20'h0_0000;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    for (int a = 0; a <= 32; a += 4) begin
      rd_chk(6'(a), 32'h0000_0000);
    end
    wr_reg(6'h3C, 32'hFFFF_FFFF);
    rd_chk(6'h3C, 32'h0000_0000);
    $display("test reset done");

    // Flag sets with everything disabled
    pulse_ev(5);
    rd_chk(`CIH_OFS_PEND, 32'h0000_0020);
    wr_reg(`CIH_OFS_PRI_EN, 32'h0000_0020);
    step(1'b0, 1'b0);
    check({31'h0, irq_req}, 32'h0000_0000);
    wr_reg(`CIH_OFS_PRI_EN, 32'h0000_0080);
    step(1'b0, 1'b0);
    wr_reg(`CIH_OFS_PRI_EN, 32'h0000_00A0);
    repeat (2) @(posedge clk);
    check({31'h0, irq_req}, 32'h0000_0001);
    step(1'b0, 1'b1);
    call_chk(5);
    rd_chk(`CIH_OFS_PEND, 32'h0000_0020);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    rd_chk(`CIH_OFS_ACTV, 32'h0000_0015);
    wr_reg(`CIH_OFS_PEND, 32'h0000_0000);
    step(1'b1, 1'b0);
    rd_chk(`CIH_OFS_ACTV, 32'h0000_0114);
    step(1'b0, 1'b0);
    $display("test enable done");

    // Every peripheral source in turn, source 6 self-clears
    wr_reg(`CIH_OFS_PRI_EN, 32'h0000_00FC);
    wr_reg(`CIH_OFS_EXT_EN1, 32'h0000_00FF);
    wr_reg(`CIH_OFS_EXT_EN2, 32'h0000_00FF);
    for (int s = 2; s < 22; s++) begin
      pulse_ev(s);
      step(1'b0, 1'b1);
      call_chk(s);
      rd_chk(`CIH_OFS_PEND, (s == 6) ? 32'h0000_0000 : (32'h1 << s));
      wr_reg(`CIH_OFS_PEND, 32'h0000_0000);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
    wr_reg(`CIH_OFS_PEND, 32'h0000_0200);
    step(1'b0, 1'b1);
    call_chk(9);
    wr_reg(`CIH_OFS_PEND, 32'h0000_0000);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    $display("test sources done");

    // Priority and preemption
    wr_reg(`CIH_OFS_PRIO, 32'h0000_0010);
    wr_reg(`CIH_OFS_PEND, 32'h0000_0018);
    step(1'b0, 1'b1);
    call_chk(4);
    step(1'b0, 1'b0);
    wr_reg(`CIH_OFS_PEND, 32'h0000_0008);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    call_chk(3);
    wr_reg(`CIH_OFS_PEND, 32'h0000_0018);
    step(1'b0, 1'b1);
    call_chk(4);
    rd_chk(`CIH_OFS_ACTV, 32'h0000_0013);
    wr_reg(`CIH_OFS_PEND, 32'h0000_0000);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    wr_reg(`CIH_OFS_PRIO, 32'h0000_0000);
    $display("test priority done");

    // External pin 0, edge then level
    wr_reg(`CIH_OFS_TCTL, 32'h0000_0001);
    wr_reg(`CIH_OFS_PRI_EN, 32'h0000_0083);
    @(posedge clk);
    edg <= 2'b01;
    @(posedge clk);
    edg <= 2'b00;
    repeat (8) @(posedge clk);
    rd_chk(`CIH_OFS_TCTL, 32'h0000_0003);
    step(1'b0, 1'b1);
    call_chk(0);
    rd_chk(`CIH_OFS_TCTL, 32'h0000_0001);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    wr_reg(`CIH_OFS_TCTL, 32'h0000_0002);
    rd_chk(`CIH_OFS_TCTL, 32'h0000_0000);
    @(posedge clk);
    lvl <= 2'b01;
    @(posedge clk);
    lvl <= 2'b00;
    repeat (6) @(posedge clk);
    rd_chk(`CIH_OFS_TCTL, 32'h0000_0002);
    step(1'b0, 1'b1);
    call_chk(0);
    repeat (6) @(posedge clk);
    rd_chk(`CIH_OFS_TCTL, 32'h0000_0000);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    $display("test ext0 done");

    // External pin 1, software set then pin edge
    // Flag write obeys the mode already in force, so select edge first
    wr_reg(`CIH_OFS_TCTL, 32'h0000_0004);
    wr_reg(`CIH_OFS_TCTL, 32'h0000_000C);
    rd_chk(`CIH_OFS_TCTL, 32'h0000_000C);
    step(1'b0, 1'b1);
    call_chk(1);
    rd_chk(`CIH_OFS_TCTL, 32'h0000_0004);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    wr_reg(`CIH_OFS_PRI_EN, 32'h0000_0000);
    @(posedge clk);
    edg <= 2'b10;
    @(posedge clk);
    edg <= 2'b00;
    repeat (8) @(posedge clk);
    rd_chk(`CIH_OFS_TCTL, 32'h0000_000C);
    $display("test ext1 done");

    // Block interrupt: sticky status, mask, read clear
    wr_reg(`CIH_OFS_TCTL, 32'h0000_0000);
    wr_reg(`CIH_OFS_MASK, 32'h0000_0001);
    bus(1'b0, `CIH_OFS_STAT, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    wr_reg(`CIH_OFS_PRI_EN, 32'h0000_00A0);
    wr_reg(`CIH_OFS_PEND, 32'h0000_0020);
    step(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    rd_chk(`CIH_OFS_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    wr_reg(`CIH_OFS_PEND, 32'h0000_0000);
    step(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    rd_chk(`CIH_OFS_STAT, 32'h0000_0002);
    $display("test status done");
    print_verdict();
  end
endmodule
